// ---- ssc_checker.sv ----
`timescale 1ns/10ps
`default_nettype none
module ssc_checker (
    // Clock and reset
    input wire logic              mclk,
    input wire logic              rst_n,
    // Register port
    input wire logic [3:0]        reg_addr,
    input wire logic              reg_rd,
    input wire logic [31:0]       reg_rdata,
    // Link
    input wire logic              rx_valid,
    input wire logic              tx_valid,
    input wire logic [7:0]        tx_data,
    input wire logic              tx_ready,
    // Machine inputs and state
    input wire logic              ext_io_on,
    input wire logic              keyswitch_on,
    input wire logic              maint_on,
    input wire ssc_pkg::ssc_ctl_t ctl
);
    import ssc_pkg::*;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    // Read data lives only in the cycle after the strobe
    AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data not zero outside a read");
    AST_STAT_READ: assert property ($past(reg_rd) && $past(reg_addr) == REG_STAT
        |-> reg_rdata == {16'h0, $past(keyswitch_on), $past(ext_io_on), $past(ctl)})
        else $error("status read does not match state");
    AST_METHOD_CODE: assert property (ctl.method inside {3'h0, 3'h1, 3'h2, 3'h3, 3'h5})
        else $error("unassigned method code");
    AST_MAINT_HOLD: assert property (maint_on [*4] |-> ctl.method == MTH_MAINT)
        else $error("method moved in maintenance");
    AST_EXT_MAP: assert property ($rose(ext_io_on) && ctl.method == MTH_PANEL && !maint_on
        |-> ##[1:3] ctl.method == MTH_EXT_PNL)
        else $error("external control did not map panel method");
    AST_EXT_FALL: assert property ($fell(ext_io_on) && ctl.method == MTH_EXT_HOST
        |-> ##[1:3] ctl.method == MTH_SERIAL)
        else $error("external control release did not restore serial");
    AST_KEY_OFF: assert property ($fell(keyswitch_on) && !ext_io_on && !maint_on
        |-> ##[1:3] ctl.method == MTH_PANEL)
        else $error("keyswitch off did not force panel");
    AST_TX_HOLD: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("transmit byte dropped while stalled");
    AST_TX_START: assert property ($rose(tx_valid) |-> tx_data == CH_STX || tx_data[7:4] == 4'h3)
        else $error("reply does not start with a unit digit");
    // Reporting only drops one edge after a frame's check byte is taken
    AST_RPT_CLEAR: assert property ($fell(ctl.report_en) |-> $past(rx_valid))
        else $error("reporting dropped without a request");

    // Main scenarios
    COV_RECORD: cover property ($rose(tx_valid) && tx_data == CH_STX);
    COV_MAINT: cover property (maint_on && ctl.method == MTH_MAINT);
    COV_EXT_HOST: cover property (ctl.method == MTH_EXT_HOST);
endmodule // ssc_checker

bind ssc_set_state_dec ssc_checker u_chk (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .rx_valid(rx_valid), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
    .ext_io_on(ext_io_on), .keyswitch_on(keyswitch_on), .maint_on(maint_on), .ctl(ctl));
`default_nettype wire

// ---- ssc_host.sv ----
`timescale 1ns/10ps
`default_nettype none
module ssc_host (
    // Clock and reset
    input wire logic       mclk,
    input wire logic       rst_n,
    // Link toward the device
    output logic           rx_valid,
    output logic [7:0]     rx_data,
    input wire logic       tx_valid,
    input wire logic [7:0] tx_data,
    output logic           tx_ready
);
    import ssc_pkg::*;
    logic [7:0] got_q [$];
    logic       stall = 1'b0;
    initial begin
        rx_valid = 1'b0;
        rx_data  = 8'h00;
        tx_ready = 1'b1;
    end
    // Sink; in stall mode it accepts only every other cycle
    always @(posedge mclk) begin
        if (rst_n && tx_valid && tx_ready)
            got_q.push_back(tx_data);
        tx_ready <= stall ? ~tx_ready : 1'b1;
    end
    // One set-state frame, a byte per cycle; short field strings pad with spaces
    task automatic send_ws(input string f, input logic bad_bcc, input logic [7:0] uo);
        logic [7:0] fr [20];
        logic [7:0] x;
        fr[0] = CH_STX;
        fr[1] = CH_0;
        fr[2] = uo;
        fr[3] = CMD_HI;
        fr[4] = CMD_LO;
        for (int i = 0; i < 13; i++)
            fr[5 + i] = (i < f.len()) ? f[i] : CH_SP;
        fr[18] = CH_ETX;
        x = 8'h00;
        for (int i = 1; i < 19; i++)
            x ^= fr[i];
        fr[19] = bad_bcc ? ~x : x;
        for (int i = 0; i < 20; i++) begin
            rx_valid <= 1'b1;
            rx_data  <= fr[i];
            @(posedge mclk);
        end
        rx_valid <= 1'b0;
        rx_data  <= ~fr[19]; // Released line shows no stale byte
    endtask
endmodule // ssc_host
`default_nettype wire

// ---- ssc_pace.sv ----
`timescale 1ns/10ps
`default_nettype none
module ssc_pace #(
    parameter int unsigned TICK_CYC = ssc_pkg::TICK_CYC
) (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_n,
    // Spacing control
    input  wire logic [15:0] gap_ms,
    input  wire logic        fire,
    output logic             ready
);
    import ssc_pkg::*;

    localparam int CW = $clog2(TICK_CYC + 1);

    typedef struct packed {
        logic [CW-1:0] div;
        logic [15:0]   left;
    } ssc_pace_st_t;

    ssc_pace_st_t s;
    ssc_pace_st_t n;
    logic         tick;

    // ------------------------------------------------------------
    // Millisecond enable and spacing countdown
    // ------------------------------------------------------------
    always_comb begin
        n = s;
        tick = (s.div == CW'(TICK_CYC - 1));
        n.div = tick ? '0 : s.div + CW'(1);
        // A fresh report restarts the gap; a stale tick must not shorten it
        if (fire) begin
            n.left = gap_ms;
        end else if (tick && s.left != 16'h0000) begin
            n.left = s.left - 16'h0001;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign ready = (s.left == 16'h0000);

endmodule // ssc_pace
`default_nettype wire

// ---- ssc_pkg.sv ----
// Notes on behaviour
// - Request is STX, unit digits, code, schedule digits, method, nine fields, flag, ETX, BCC.
// - Unit number is two digits, tens first; reply echoes them before ACK or NAK.
// - Schedule digits 00 to 31 select the active schedule.
// - Two spaces in the schedule digits keep the present schedule.
// - Method codes: 0 panel, 1 ext I/O panel, 2 serial, 3 maintenance, 5 ext I/O host.
// - Only method requests 0 and 2 act; anything else leaves the method alone.
// - In maintenance a request to change the method is refused.
// - Keyswitch turning off with external I/O off forces panel control, except in maintenance.
// - External I/O maps request 0 to method 1 and 2 to 5, in any order.
// - External I/O turning off maps method 1 to 0 and 5 to 2.
// - High-voltage and guide-light fields: 0 off, 1 on, space keeps.
// - Fields four to six drive shutters one to three: 0 closed, 1 open, space keeps.
// - Report flag 1 sends a monitor record per lamp firing, 0 stops, space keeps.
// - Fast firing sends reports only at spaced intervals.
// - Reporting stays on until a report flag 0 or reset, whatever the method does.
// - ACK or NAK goes out only under serial control.
// - One bad field discards the whole request and answers NAK.
// - Record holds schedule, lamp power, energy, sample count up to 108, pulse width.
package ssc_pkg;

    // ------------------------------------------------------------
    // Characters on the link
    // ------------------------------------------------------------
    localparam logic [7:0] CH_STX = 8'h02;
    localparam logic [7:0] CH_ETX = 8'h03;
    localparam logic [7:0] CH_ACK = 8'h06;
    localparam logic [7:0] CH_NAK = 8'h15;
    localparam logic [7:0] CH_SP  = 8'h20;
    localparam logic [7:0] CH_0   = 8'h30;
    localparam logic [7:0] CH_1   = 8'h31;
    localparam logic [7:0] CH_2   = 8'h32;
    localparam logic [7:0] CMD_HI = 8'h57;
    localparam logic [7:0] CMD_LO = 8'h53;
    localparam logic [7:0] REP_HI = 8'h52;

    // ------------------------------------------------------------
    // Frame layout (position 0 is STX)
    // ------------------------------------------------------------
    localparam logic [4:0] POS_UNIT_T = 5'h01;
    localparam logic [4:0] POS_UNIT_O = 5'h02;
    localparam logic [4:0] POS_CMD_HI = 5'h03;
    localparam logic [4:0] POS_CMD_LO = 5'h04;
    localparam logic [4:0] POS_FLD    = 5'h05;
    localparam logic [4:0] POS_ETX    = 5'h12;
    localparam logic [4:0] POS_BCC    = 5'h13;
    localparam int         FLD_N      = 13;
    localparam int F_SH1 = 0;
    localparam int F_SH0 = 1;
    localparam int F_CNT = 2;
    localparam int F_HV  = 3;
    localparam int F_GL  = 4;
    localparam int F_S3  = 5;
    localparam int F_SHT = 6;
    localparam int F_S7  = 9;
    localparam int F_S8  = 10;
    localparam int F_S9  = 11;
    localparam int F_MON = 12;
    localparam logic [6:0] SCHED_MAX = 7'h1f;
    localparam logic [4:0] RPL_LEN   = 5'h03;
    localparam logic [4:0] REP_LEN   = 5'h17;
    localparam logic [11:0] SAMPLES_MAX = 12'h108;

    // ------------------------------------------------------------
    // Control method codes
    // ------------------------------------------------------------
    localparam logic [2:0] MTH_PANEL    = 3'h0;
    localparam logic [2:0] MTH_EXT_PNL  = 3'h1;
    localparam logic [2:0] MTH_SERIAL   = 3'h2;
    localparam logic [2:0] MTH_MAINT    = 3'h3;
    localparam logic [2:0] MTH_EXT_HOST = 3'h5;

    // ------------------------------------------------------------
    // Registers, resets and timing
    // ------------------------------------------------------------
    localparam logic [3:0]  REG_UNIT = 4'h0;
    localparam logic [3:0]  REG_GAP  = 4'h4;
    localparam logic [3:0]  REG_STAT = 4'h8;
    localparam logic [7:0]  UNIT_RST = 8'h01;
    localparam logic [15:0] GAP_RST  = 16'h000a;
    localparam int CLK_NS   = 25;
    localparam int TICK_NS  = 1000000;
    localparam int TICK_CYC = TICK_NS / CLK_NS;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2:0] method;
        logic [4:0] schedule;
        logic       hv;
        logic       guide;
        logic [2:0] shutter;
        logic       report_en;
    } ssc_ctl_t;

    // BCD digits, most significant digit at the highest index
    typedef struct packed {
        logic [1:0][3:0] sched;
        logic [2:0][3:0] lamp;
        logic [3:0][3:0] energy;
        logic [2:0][3:0] samples;
        logic [2:0][3:0] width;
    } ssc_rec_t;

endpackage

// ---- ssc_set_state_dec.sv ----
`timescale 1ns/10ps
`default_nettype none
module ssc_set_state_dec #(
    parameter int unsigned TICK_CYC = ssc_pkg::TICK_CYC
) (
    // Clock and reset
    input  wire logic               mclk,
    input  wire logic               rst_n,
    // Register port
    input  wire logic [3:0]         reg_addr,
    input  wire logic [31:0]        reg_wdata,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    output logic [31:0]             reg_rdata,
    // Received bytes
    input  wire logic               rx_valid,
    input  wire logic [7:0]         rx_data,
    // Transmitted bytes
    output logic                    tx_valid,
    output logic [7:0]              tx_data,
    input  wire logic               tx_ready,
    // Machine inputs
    input  wire logic               ext_io_on,
    input  wire logic               keyswitch_on,
    input  wire logic               maint_on,
    input  wire logic               lamp_fired,
    input  wire ssc_pkg::ssc_rec_t  mon_rec,
    // Applied state
    output ssc_pkg::ssc_ctl_t       ctl
);
    import ssc_pkg::*;

    typedef struct packed {
        ssc_ctl_t                 ctl;
        logic [7:0]               uid;
        logic [15:0]              gap;
        logic [31:0]              rdata;
        logic [4:0]               ridx;
        logic [7:0]               rbcc;
        logic                     hit;
        logic [FLD_N-1:0][7:0]    fld;
        logic                     ext_d;
        logic                     key_d;
        logic                     maint_d;
        logic                     tx_busy;
        logic                     tx_rep;
        logic                     tx_ack;
        logic [4:0]               tx_idx;
        logic [7:0]               tx_byte;
        logic [7:0]               tx_bcc;
        logic                     rpl_pend;
        logic                     rpl_ack;
        logic                     rep_pend;
        ssc_rec_t                 rec;
    } ssc_dec_st_t;

    ssc_dec_st_t s;
    ssc_dec_st_t n;
    logic        good;
    logic        bad;
    logic        req;
    logic        rpl;
    logic        sch_keep;
    logic        sch_ok;
    logic [6:0]  sch_v;
    logic [2:0]  base_m;
    logic [2:0]  new_m;
    logic [1:0]  d_hv;
    logic [1:0]  d_gl;
    logic [1:0]  d_mon;
    logic [2:0][1:0] d_sh;
    logic [7:0]  nbcc;
    logic [4:0]  len;
    logic        rep_go;
    logic        pace_ok;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Switch field: 00 off, 01 on, 10 keep, 11 illegal
    function automatic logic [1:0] sw_dec(input logic [7:0] c);
        if (c == CH_0) return 2'b00;
        if (c == CH_1) return 2'b01;
        if (c == CH_SP) return 2'b10;
        return 2'b11;
    endfunction

    function automatic logic is_dig(input logic [7:0] c);
        return (c >= CH_0) && (c <= 8'h39);
    endfunction

    // Sample count never reported above its ceiling
    function automatic ssc_rec_t rec_clamp(input ssc_rec_t r);
        ssc_rec_t c;
        c = r;
        if (r.samples[2] > 4'h1 || (r.samples[2] == 4'h1 && (r.samples[1] != 4'h0 || r.samples[0] > 4'h8)))
            c.samples = SAMPLES_MAX;
        return c;
    endfunction

    // Byte k of the reply (no STX) or of the monitor record
    function automatic logic [7:0] tx_gen(input logic rep, input logic [4:0] k, input logic [7:0] bcc,
                                          input logic ack, input logic [7:0] uid, input ssc_rec_t rec);
        logic [14:0][3:0] dg;
        logic [4:0]       o;
        dg = rec;
        o = rep ? k : k + 5'h01;
        if (o == 5'h00) return CH_STX;
        if (o == 5'h01) return {4'h3, uid[7:4]};
        if (o == 5'h02) return {4'h3, uid[3:0]};
        if (!rep) return ack ? CH_ACK : CH_NAK;
        if (o == 5'h03) return REP_HI;
        if (o <= 5'h05) return CH_0;
        if (o <= 5'h14) return {4'h3, dg[5'h14 - o]};
        if (o == 5'h15) return CH_ETX;
        return bcc;
    endfunction

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        n = s;
        n.ext_d = ext_io_on;
        n.key_d = keyswitch_on;
        n.maint_d = maint_on;
        nbcc = 8'h00;
        len = RPL_LEN;

        // Register writes steer unit number and report spacing
        if (reg_wr && reg_addr == REG_UNIT) n.uid = reg_wdata[7:0];
        if (reg_wr && reg_addr == REG_GAP) n.gap = reg_wdata[15:0];
        // Read data valid for the one cycle after the strobe
        n.rdata = 32'h0000_0000;
        if (reg_rd) begin
            unique case (reg_addr)
                REG_UNIT: n.rdata = {24'h00_0000, s.uid};
                REG_GAP:  n.rdata = {16'h0000, s.gap};
                REG_STAT: n.rdata = {16'h0000, keyswitch_on, ext_io_on, s.ctl};
                default:  n.rdata = 32'h0000_0000;
            endcase
        end

        // Method follows external I/O, keyswitch and maintenance edges
        if (ext_io_on && !s.ext_d) begin
            if (s.ctl.method == MTH_PANEL) n.ctl.method = MTH_EXT_PNL;
            if (s.ctl.method == MTH_SERIAL) n.ctl.method = MTH_EXT_HOST;
        end
        if (!ext_io_on && s.ext_d) begin
            if (s.ctl.method == MTH_EXT_PNL) n.ctl.method = MTH_PANEL;
            if (s.ctl.method == MTH_EXT_HOST) n.ctl.method = MTH_SERIAL;
        end
        if (!keyswitch_on && s.key_d && !ext_io_on && s.ctl.method != MTH_MAINT)
            n.ctl.method = MTH_PANEL;
        if (maint_on && !s.maint_d) n.ctl.method = MTH_MAINT;
        if (!maint_on && s.maint_d) n.ctl.method = MTH_PANEL;
        base_m = n.ctl.method;

        // Field decode of the captured request
        sch_keep = s.fld[F_SH1] == CH_SP && s.fld[F_SH0] == CH_SP;
        sch_v = 7'(s.fld[F_SH1][3:0]) * 7'h0a + 7'(s.fld[F_SH0][3:0]);
        sch_ok = is_dig(s.fld[F_SH1]) && is_dig(s.fld[F_SH0]) && sch_v <= SCHED_MAX;
        req = s.fld[F_CNT] == CH_0 || s.fld[F_CNT] == CH_2;
        if (ext_io_on)
            new_m = (s.fld[F_CNT] == CH_0) ? MTH_EXT_PNL : MTH_EXT_HOST;
        else
            new_m = (s.fld[F_CNT] == CH_0) ? MTH_PANEL : MTH_SERIAL;
        d_hv = sw_dec(s.fld[F_HV]);
        d_gl = sw_dec(s.fld[F_GL]);
        d_mon = sw_dec(s.fld[F_MON]);
        for (int i = 0; i < 3; i++) begin
            d_sh[i] = sw_dec(s.fld[F_SHT + i]);
        end
        // Any unusable field spoils the whole request
        bad = (!sch_keep && !sch_ok) || (req && base_m == MTH_MAINT)
            || d_hv == 2'b11 || d_gl == 2'b11 || d_mon == 2'b11
            || d_sh[0] == 2'b11 || d_sh[1] == 2'b11 || d_sh[2] == 2'b11
            || s.fld[F_S3] != CH_SP || s.fld[F_S7] != CH_SP
            || s.fld[F_S8] != CH_SP || s.fld[F_S9] != CH_SP;
        good = rx_valid && s.ridx == POS_BCC && s.hit && rx_data == s.rbcc;
        rpl = base_m == MTH_SERIAL || (!bad && req && new_m == MTH_SERIAL);

        // Request framing; a wrong unit or code just drops the frame
        if (rx_valid) begin
            if (s.ridx == POS_BCC) begin
                n.ridx = 5'h00;
            end else if (rx_data == CH_STX) begin
                n.ridx = POS_UNIT_T;
                n.rbcc = 8'h00;
                n.hit = 1'b1;
            end else if (s.ridx != 5'h00) begin
                n.ridx = s.ridx + 5'h01;
                n.rbcc = s.rbcc ^ rx_data;
                if (s.ridx == POS_UNIT_T && rx_data != {4'h3, s.uid[7:4]}) n.hit = 1'b0;
                if (s.ridx == POS_UNIT_O && rx_data != {4'h3, s.uid[3:0]}) n.hit = 1'b0;
                if (s.ridx == POS_CMD_HI && rx_data != CMD_HI) n.hit = 1'b0;
                if (s.ridx == POS_CMD_LO && rx_data != CMD_LO) n.hit = 1'b0;
                if (s.ridx == POS_ETX && rx_data != CH_ETX) n.hit = 1'b0;
                if (s.ridx >= POS_FLD && s.ridx < POS_ETX) n.fld[s.ridx - POS_FLD] = rx_data;
            end
        end

        // Commit all fields together, or none
        if (good && !bad) begin
            if (sch_ok) n.ctl.schedule = sch_v[4:0];
            if (req) n.ctl.method = new_m;
            if (!d_hv[1]) n.ctl.hv = d_hv[0];
            if (!d_gl[1]) n.ctl.guide = d_gl[0];
            // Only the flag clears reporting; method changes leave it
            if (!d_mon[1]) n.ctl.report_en = d_mon[0];
            for (int i = 0; i < 3; i++) begin
                if (!d_sh[i][1]) n.ctl.shutter[i] = d_sh[i][0];
            end
        end

        // Transmitter: one byte per accepted handshake
        if (s.tx_busy) begin
            if (tx_ready) begin
                nbcc = s.tx_bcc ^ ((s.tx_idx == 5'h00) ? 8'h00 : s.tx_byte);
                len = s.tx_rep ? REP_LEN : RPL_LEN;
                if (s.tx_idx == len - 5'h01) begin
                    n.tx_busy = 1'b0;
                end else begin
                    n.tx_idx = s.tx_idx + 5'h01;
                    n.tx_bcc = nbcc;
                    n.tx_byte = tx_gen(s.tx_rep, s.tx_idx + 5'h01, nbcc, s.tx_ack, s.uid, s.rec);
                end
            end
        end else if (s.rpl_pend) begin
            // Replies go first; a record can wait a few bytes
            n.tx_busy = 1'b1;
            n.tx_rep = 1'b0;
            n.tx_ack = s.rpl_ack;
            n.tx_idx = 5'h00;
            n.tx_bcc = 8'h00;
            n.tx_byte = tx_gen(1'b0, 5'h00, 8'h00, s.rpl_ack, s.uid, s.rec);
            n.rpl_pend = 1'b0;
        end else if (s.rep_pend) begin
            n.tx_busy = 1'b1;
            n.tx_rep = 1'b1;
            n.tx_idx = 5'h00;
            n.tx_bcc = 8'h00;
            n.tx_byte = CH_STX;
            n.rep_pend = 1'b0;
        end

        // Pending flags set after the clears so a same-cycle event wins
        if (good && rpl) begin
            n.rpl_pend = 1'b1;
            n.rpl_ack = !bad;
        end
        // Firings inside the gap or during a record send nothing
        rep_go = lamp_fired && s.ctl.report_en && pace_ok && !s.rep_pend
               && !(s.tx_busy && s.tx_rep);
        if (rep_go) begin
            n.rep_pend = 1'b1;
            n.rec = rec_clamp(mon_rec);
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
            s.uid <= UNIT_RST;
            s.gap <= GAP_RST;
            s.ctl.method <= MTH_PANEL;
        end else begin
            s <= n;
        end
    end

    // ------------------------------------------------------------
    // Report spacing timer
    // ------------------------------------------------------------
    ssc_pace #(
        .TICK_CYC (TICK_CYC)
    ) u_pace (
        .mclk   (mclk),
        .rst_n  (rst_n),
        .gap_ms (s.gap),
        .fire   (rep_go),
        .ready  (pace_ok)
    );

    // Outputs
    assign tx_valid = s.tx_busy;
    assign tx_data = s.tx_byte;
    assign reg_rdata = s.rdata;
    assign ctl = s.ctl;

endmodule // ssc_set_state_dec
`default_nettype wire

// ---- tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb;
    import ssc_pkg::*;
    logic        mclk         = 1'b0;
    logic        rst_n        = 1'b0;
    logic [3:0]  reg_addr     = 4'h0;
    logic [31:0] reg_wdata    = 32'h0;
    logic        reg_wr       = 1'b0;
    logic        reg_rd       = 1'b0;
    logic        ext_io_on    = 1'b0;
    logic        keyswitch_on = 1'b1;
    logic        maint_on     = 1'b0;
    logic        lamp_fired   = 1'b0;
    ssc_rec_t    mon_rec      = {8'h31, 12'h123, 16'h4567, 12'h999, 12'h050};
    logic [31:0] reg_rdata;
    logic        rx_valid;
    logic        tx_valid;
    logic        tx_ready;
    logic [7:0]  rx_data;
    logic [7:0]  tx_data;
    ssc_ctl_t    ctl;
    int          fails        = 0;
    int          num_checks   = 0;

    always #12.5 mclk = ~mclk;

    ssc_set_state_dec #(.TICK_CYC(10)) DUT (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_valid(rx_valid),
        .rx_data(rx_data), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .ext_io_on(ext_io_on),
        .keyswitch_on(keyswitch_on), .maint_on(maint_on), .lamp_fired(lamp_fired), .mon_rec(mon_rec), .ctl(ctl));
    ssc_host host (.mclk(mclk), .rst_n(rst_n), .rx_valid(rx_valid), .rx_data(rx_data), .tx_valid(tx_valid),
        .tx_data(tx_data), .tx_ready(tx_ready));

    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
        num_checks++;
        if (x !== g) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", n, x, g);
        end
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge mclk);
        reg_wr    <= 1'b0;
    endtask
    // Data stands only until the next edge, so look just after the strobe edge
    task automatic rd(input logic [3:0] a, input logic [31:0] x, input string n);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge mclk);
        reg_rd   <= 1'b0;
        #1 chk(n, x, reg_rdata);
    endtask
    // Reply is due two edges after the check byte; 40 cycles covers three bytes
    task automatic ws(input string f, input logic bad, input logic [7:0] uo, input logic [7:0] code);
        host.send_ws(f, bad, uo);
        repeat (40) @(posedge mclk);
        chk("reply size", (code === 8'h00) ? 32'h0 : 32'h3, 32'(host.got_q.size()));
        if (code !== 8'h00 && host.got_q.size() == 3)
            chk("reply", {8'h0, CH_0, CH_1, code}, {8'h0, host.got_q[0], host.got_q[1], host.got_q[2]});
        host.got_q.delete();
    endtask
    task automatic cc(input logic [13:0] x);
        chk("ctl", {18'h0, x}, {18'h0, ctl});
    endtask
    task automatic mth(input logic [2:0] x);
        repeat (4) @(posedge mclk);
        chk("method", {29'h0, x}, {29'h0, ctl.method});
    endtask
    task automatic fire;
        lamp_fired <= 1'b1;
        @(posedge mclk);
        lamp_fired <= 1'b0;
    endtask
    // Summary record: header, fifteen digits, samples clipped to 108, check byte
    task automatic rec_chk;
        logic [7:0] e [$];
        logic [7:0] x;
        string      s;
        e = {CH_STX, CH_0, CH_1, REP_HI, CH_0, CH_0};
        s = "311234567108050";
        for (int i = 0; i < 15; i++)
            e.push_back(s[i]);
        e.push_back(CH_ETX);
        x = 8'h00;
        for (int i = 1; i < e.size(); i++)
            x ^= e[i];
        e.push_back(x);
        repeat (120) @(posedge mclk);
        chk("record size", 32'd23, 32'(host.got_q.size()));
        for (int i = 0; i < 23 && i < host.got_q.size(); i++)
            chk("record byte", {24'h0, e[i]}, {24'h0, host.got_q[i]});
        host.got_q.delete();
    endtask

    // Watchdog well beyond the eleven hundred or so cycles the sequence needs
    initial begin
        repeat (20000) @(posedge mclk);
        fails++;
        close_out();
    end

    // Main sequence
    initial begin
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        rd(REG_STAT, 32'h0000_8000, "status");
        rd(REG_UNIT, {24'h0, UNIT_RST}, "unit");
        rd(REG_GAP, {16'h0, GAP_RST}, "gap");
        rd(4'hc, 32'h0, "unmapped");
        wr(REG_GAP, 32'h8);
        rd(REG_GAP, 32'h8, "gap written");
        ws("  2", 1'b0, CH_1, CH_ACK);
        cc({MTH_SERIAL, 5'h00, 6'h00});
        ws("31 11 110", 1'b0, CH_1, CH_ACK);
        cc({MTH_SERIAL, 5'h1f, 6'h36});
        ws("   0", 1'b0, CH_1, CH_ACK);
        cc({MTH_SERIAL, 5'h1f, 6'h16});
        ws("05 1 0", 1'b0, CH_1, CH_NAK);
        cc({MTH_SERIAL, 5'h1f, 6'h16});
        ws("   1", 1'b1, CH_1, 8'h00);
        ws("   1", 1'b0, CH_2, 8'h00);
        ws("  3", 1'b0, CH_1, CH_ACK);
        cc({MTH_SERIAL, 5'h1f, 6'h16});
        ws({"      ", "      ", "1"}, 1'b0, CH_1, CH_ACK);
        cc({MTH_SERIAL, 5'h1f, 6'h17});
        host.stall = 1'b1;
        fire();
        // Second firing comes after the record ends but inside the gap
        repeat (60) @(posedge mclk);
        fire();
        rec_chk();
        ws("  0", 1'b0, CH_1, CH_ACK);
        cc({MTH_PANEL, 5'h1f, 6'h17});
        fire();
        rec_chk();
        ws("   0", 1'b0, CH_1, 8'h00);
        ext_io_on <= 1'b1;
        mth(MTH_EXT_PNL);
        host.send_ws("  2", 1'b0, CH_1);
        mth(MTH_EXT_HOST);
        ext_io_on <= 1'b0;
        mth(MTH_SERIAL);
        keyswitch_on <= 1'b0;
        mth(MTH_PANEL);
        keyswitch_on <= 1'b1;
        maint_on <= 1'b1;
        mth(MTH_MAINT);
        host.send_ws("  2", 1'b0, CH_1);
        mth(MTH_MAINT);
        maint_on <= 1'b0;
        mth(MTH_PANEL);
        ws({"      ", "      ", "0"}, 1'b0, CH_1, 8'h00);
        cc({MTH_PANEL, 5'h1f, 6'h16});
        fire();
        repeat (40) @(posedge mclk);
        chk("record off", 32'h0, 32'(host.got_q.size()));
        close_out();
    end
endmodule // tb
`default_nettype wire
